// ===== src/serial_line_powerdown_control.sv
// Operation
// - Low shutdown_n forces powerdown, overriding stay_awake.
// - Any powerdown stops the charge pump and floats all transmitters.
// - Manual powerdown also floats the inverting receiver outputs.
// - High stay_awake disables inactivity powerdown; only shutdown_n stops it.
// - Automatic powerdown armed only with stay_awake low and shutdown_n high.
// - Thirty seconds without any line edge powers the device down.
// - Any transmitter or receiver input edge leaves automatic powerdown.
// - After automatic powerdown the timer stays expired until stay_awake rises or edge.
// - Manual powerdown ends on both controls high, or on an edge with shutdown_n high.
// - Falling stay_awake restarts the thirty second interval.
// - Transmission resumes within 25 us of leaving powerdown.
// - lines_valid falls after invalid levels persist on all receivers past delay.
// - lines_valid rises about 1 us after any receiver shows valid level.
// - lines_valid never affects power state and works in every mode.
// - lines_valid on shutdown_n only: stays down after valid until an edge.
// - Inverting receivers stay active in automatic powerdown.
// - Monitor receiver output is always active.
// - An edge is a threshold crossing on a transmitter or receiver input.
`timescale 1ns/1ps
`default_nettype none
`include "pwrdn_params.svh"
module serial_line_powerdown_control #(
   parameter int IDLE_CYCLES = `IDLE_CYCLES,
   parameter int INVL_CYCLES = `INVL_CYCLES
) (
   // Clock and reset
   input  wire logic                    CLOCK_I,
   input  wire logic                    RSTN_I,
   // Control pins
   input  wire logic                    SHUTDOWN_N_I,
   input  wire logic                    STAY_AWAKE_I,
   // Line inputs after threshold detection
   input  wire logic [`NUM_TX-1:0]      TX_IN_I,
   input  wire logic [`NUM_RX-1:0]      RX_IN_I,
   input  wire logic [`NUM_RX-1:0]      RX_LEVEL_VALID_I,
   input  wire logic                    MONITOR_RX_IN_I,
   // Power and output enables
   output logic                         CHARGE_PUMP_EN_O,
   output logic                         TX_OUT_OE_N_O,
   output logic                         RX_OUT_OE_N_O,
   output logic                         MONITOR_RX_OUT_O,
   output pwrdn_pkg::pwr_state_t        STATE_O,
   // Status
   output logic                         LINES_VALID_O
);
   import pwrdn_pkg::*;

   localparam int WAKE_CYCLES = `WAKE_CYCLES;
   localparam int INVH_CYCLES = `INVH_CYCLES;

   logic [1:0]         ctl_sync;
   logic               line_edge;
   logic [`NUM_RX-1:0] valid_sync;
   logic               mon_sync;

   // Controls idle high in reset, else leaving reset would look like a shutdown
   line_sync #(.W(2), .INIT(2'h3)) u_ctl (
      .clk_i   (CLOCK_I),
      .rstn_i  (RSTN_I),
      .async_i ({STAY_AWAKE_I, SHUTDOWN_N_I}),
      .sync_o  (ctl_sync),
      .edge_o  ()
   );
   line_sync #(.W(`NUM_TX+`NUM_RX)) u_line (
      .clk_i   (CLOCK_I),
      .rstn_i  (RSTN_I),
      .async_i ({TX_IN_I, RX_IN_I}),
      .sync_o  (),
      .edge_o  (line_edge)
   );
   line_sync #(.W(`NUM_RX)) u_valid (
      .clk_i   (CLOCK_I),
      .rstn_i  (RSTN_I),
      .async_i (RX_LEVEL_VALID_I),
      .sync_o  (valid_sync),
      .edge_o  ()
   );
   line_sync #(.W(1)) u_mon (
      .clk_i   (CLOCK_I),
      .rstn_i  (RSTN_I),
      .async_i (MONITOR_RX_IN_I),
      .sync_o  (mon_sync),
      .edge_o  ()
   );

   wire shutdown_n = ctl_sync[0];
   wire stay_awake = ctl_sync[1];
   wire any_valid  = |valid_sync;

   logic stay_last_ff;
   wire  stay_rise = stay_awake & ~stay_last_ff;
   wire  stay_fall = ~stay_awake & stay_last_ff;

   pwr_state_t state_ff;
   pwr_state_t nxt_state;
   logic [`IDLE_W-1:0]  idle_ff;
   logic [`IDLE_W-1:0]  nxt_idle;
   logic [`SHORT_W-1:0] wake_ff;
   logic [`SHORT_W-1:0] inv_ff;
   logic                lines_valid_ff;

   wire armed     = ~stay_awake & shutdown_n;
   wire idle_done = (idle_ff == `IDLE_W'(IDLE_CYCLES - 1));
   wire man_leave = (shutdown_n & stay_awake) | (shutdown_n & line_edge);
   wire wake_done = (wake_ff == `SHORT_W'(WAKE_CYCLES - 1));

   // Idle counter restarts on edges and falling stay_awake
   always_comb begin
      nxt_idle = idle_ff;
      if (line_edge || stay_fall || !armed) begin
         nxt_idle = '0;
      end else if (!idle_done) begin
         nxt_idle = idle_ff + `IDLE_W'(1);
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         PWR_ACTIVE: begin
            if (!shutdown_n) begin
               nxt_state = PWR_MANUAL_DOWN;
            end else if (armed && idle_done && !line_edge) begin
               nxt_state = PWR_AUTO_DOWN;
            end
         end
         PWR_WAKING: begin
            if (!shutdown_n) begin
               nxt_state = PWR_MANUAL_DOWN;
            end else if (wake_done) begin
               nxt_state = PWR_ACTIVE;
            end
         end
         PWR_AUTO_DOWN: begin
            if (!shutdown_n) begin
               nxt_state = PWR_MANUAL_DOWN;
            end else if (line_edge || stay_rise || stay_awake) begin
               nxt_state = PWR_WAKING;
            end
         end
         PWR_MANUAL_DOWN: begin
            // with stay_awake low, stays down after release until edge
            if (man_leave) begin
               nxt_state = PWR_WAKING;
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_ff     <= PWR_ACTIVE;
         idle_ff      <= '0;
         wake_ff      <= '0;
         stay_last_ff <= 1'b1;
      end else begin
         state_ff     <= nxt_state;
         idle_ff      <= nxt_idle;
         stay_last_ff <= stay_awake;
         wake_ff      <= (state_ff == PWR_WAKING) ? wake_ff + `SHORT_W'(1) : '0;
      end
   end

   // status filter, independent of power state
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         inv_ff         <= '0;
         lines_valid_ff <= 1'b0;
      end else if (any_valid != lines_valid_ff) begin
         if ((any_valid && inv_ff >= `SHORT_W'(INVH_CYCLES - 1)) ||
             (!any_valid && inv_ff >= `SHORT_W'(INVL_CYCLES - 1))) begin
            lines_valid_ff <= any_valid;
            inv_ff         <= '0;
         end else begin
            inv_ff <= inv_ff + `SHORT_W'(1);
         end
      end else begin
         inv_ff <= '0;
      end
   end

   wire powered = (state_ff == PWR_ACTIVE);
   // pump and transmitters off when down
   assign CHARGE_PUMP_EN_O = (state_ff == PWR_ACTIVE) || (state_ff == PWR_WAKING);
   assign TX_OUT_OE_N_O    = ~powered;
   // receivers float only in manual powerdown
   assign RX_OUT_OE_N_O    = (state_ff == PWR_MANUAL_DOWN);
   assign MONITOR_RX_OUT_O = mon_sync;
   assign STATE_O          = state_ff;
   assign LINES_VALID_O    = lines_valid_ff;

   // Assertions
   property p_shut_wins;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      !shutdown_n |=> state_ff == PWR_MANUAL_DOWN;
   endproperty
   a_shut_wins: assert property (p_shut_wins) else $error("shutdown did not win");

   property p_tx_float;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      (state_ff == PWR_AUTO_DOWN || state_ff == PWR_MANUAL_DOWN) |->
         TX_OUT_OE_N_O && !CHARGE_PUMP_EN_O;
   endproperty
   a_tx_float: assert property (p_tx_float) else $error("tx active in powerdown");

   property p_rx_manual;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      RX_OUT_OE_N_O |-> state_ff == PWR_MANUAL_DOWN;
   endproperty
   a_rx_manual: assert property (p_rx_manual) else $error("rx floated outside manual");

   property p_no_auto_awake;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      (state_ff == PWR_ACTIVE && stay_awake && shutdown_n) |=> state_ff == PWR_ACTIVE;
   endproperty
   a_no_auto_awake: assert property (p_no_auto_awake) else $error("auto down while awake");

   property p_edge_wakes;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      (state_ff == PWR_AUTO_DOWN && line_edge && shutdown_n) |=> state_ff == PWR_WAKING;
   endproperty
   a_edge_wakes: assert property (p_edge_wakes) else $error("edge did not wake");

   property p_wake_time;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      ($rose(state_ff == PWR_WAKING) && shutdown_n) |-> ##[1:260] !TX_OUT_OE_N_O || !shutdown_n;
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("wake too slow");

   property p_idle_down;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      (state_ff == PWR_ACTIVE && armed && idle_done && !line_edge) |=> state_ff == PWR_AUTO_DOWN;
   endproperty
   a_idle_down: assert property (p_idle_down) else $error("timeout ignored");

   property p_valid_up;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      (any_valid && !lines_valid_ff) [*8] ##1 any_valid ##1 any_valid |=> lines_valid_ff;
   endproperty
   a_valid_up: assert property (p_valid_up) else $error("status rise late");

   property p_valid_hold;
      @(posedge CLOCK_I) disable iff (!RSTN_I)
      $fell(lines_valid_ff) |-> !$past(any_valid, 8);
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("status fell early");

   c_auto: cover property (@(posedge CLOCK_I) state_ff == PWR_AUTO_DOWN);
   c_manual: cover property (@(posedge CLOCK_I) state_ff == PWR_MANUAL_DOWN);
   c_wake: cover property (@(posedge CLOCK_I) $rose(state_ff == PWR_ACTIVE));
   c_invalid: cover property (@(posedge CLOCK_I) $fell(LINES_VALID_O));
endmodule
`default_nettype wire

// ===== src/pwrdn_params.svh
`ifndef PWRDN_PARAMS_SVH
`define PWRDN_PARAMS_SVH
// Reference clock in kHz (10 MHz)
`define CLK_KHZ          10000
// Line counts
`define NUM_TX           5
`define NUM_RX           3
// Inactivity interval, seconds
`define IDLE_TIME_S      30
`define IDLE_CYCLES      (`IDLE_TIME_S * `CLK_KHZ * 1000)
// Wake-up delay, microseconds (longest: round down)
`define WAKE_TIME_US     25
`define WAKE_CYCLES      ((`WAKE_TIME_US * `CLK_KHZ) / 1000)
// Status-low delay, microseconds (least: round up)
`define INVL_TIME_US     60
`define INVL_CYCLES      ((`INVL_TIME_US * `CLK_KHZ + 999) / 1000)
// Status-high delay, microseconds
`define INVH_TIME_US     1
`define INVH_CYCLES      ((`INVH_TIME_US * `CLK_KHZ) / 1000)
// Counter widths
`define IDLE_W           29
`define SHORT_W          16
`endif

// ===== src/pwrdn_pkg.sv
package pwrdn_pkg;
   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_WAKING,
      PWR_AUTO_DOWN,
      PWR_MANUAL_DOWN
   } pwr_state_t;
endpackage

// ===== src/line_sync.sv
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   // Lines
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o,
   output logic              edge_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] last_ff;
   logic         edge_ff;

   // Reset to the idle level so that leaving reset shows no false level or edge
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_ff <= INIT;
         sync_ff <= INIT;
         last_ff <= INIT;
         edge_ff <= 1'b0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         edge_ff <= |(sync_ff ^ last_ff);
      end
   end

   assign sync_o = sync_ff;
   assign edge_o = edge_ff;
endmodule
`default_nettype wire

// ===== tb/host_pwr_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_pwr_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Host commands and device status
   input  wire logic [1:0] mode_i,
   input  wire logic       off_n_i,
   input  wire logic       awake_i,
   input  wire logic       lines_valid_i,
   // Control pins
   output logic            shutdown_n_o,
   output logic            stay_awake_o
);
   logic       prev_ff;
   logic [2:0] pulse_ff;
   logic       rise;
   assign rise = off_n_i & ~prev_ff;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shutdown_n_o <= 1'b1;
         stay_awake_o <= 1'b1;
         prev_ff      <= 1'b1;
         pulse_ff     <= 3'h0;
      end else begin
         prev_ff  <= off_n_i;
         pulse_ff <= rise ? 3'h4 : ((pulse_ff != 3'h0) ? pulse_ff - 3'h1 : 3'h0);
         case (mode_i)
            2'h1: begin
               shutdown_n_o <= lines_valid_i;
               stay_awake_o <= lines_valid_i;
            end
            2'h2: begin
               shutdown_n_o <= lines_valid_i;
               stay_awake_o <= 1'b0;
            end
            // short keep-awake pulse on master release
            2'h3: begin
               shutdown_n_o <= off_n_i;
               stay_awake_o <= rise | (pulse_ff != 3'h0);
            end
            default: begin
               shutdown_n_o <= off_n_i;
               stay_awake_o <= awake_i;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_serial_line_powerdown_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwrdn_params.svh"
module tb_serial_line_powerdown_control;
   import pwrdn_pkg::*;
   localparam int IDLE = 400;
   localparam int INVL = 600;
   localparam int WK   = `WAKE_CYCLES + 10;
   logic                       clk   = 1'b0;
   logic                       rstn  = 1'b0;
   logic                       off_n = 1'b1;
   logic                       awake = 1'b1;
   logic [1:0]                 mode  = 2'h0;
   logic [`NUM_TX+`NUM_RX-1:0] lin   = '0;
   logic [`NUM_RX-1:0]         lvl   = '1;
   logic                       mon   = 1'b0;
   logic                       sd_n, sa, pump, tx_oe_n, rx_oe_n, mon_o, lv;
   pwr_state_t                 st;
   int                         error_cnt   = 0;
   int                         comparisons = 0;

   always #50 clk = ~clk;

   host_pwr_model host_u (.clk_i(clk), .rstn_i(rstn), .mode_i(mode), .off_n_i(off_n),
      .awake_i(awake), .lines_valid_i(lv), .shutdown_n_o(sd_n), .stay_awake_o(sa));

   serial_line_powerdown_control #(.IDLE_CYCLES(IDLE), .INVL_CYCLES(INVL)) dut_u (
      .CLOCK_I(clk), .RSTN_I(rstn), .SHUTDOWN_N_I(sd_n), .STAY_AWAKE_I(sa),
      .TX_IN_I(lin[`NUM_TX-1:0]), .RX_IN_I(lin[`NUM_TX+`NUM_RX-1:`NUM_TX]),
      .RX_LEVEL_VALID_I(lvl), .MONITOR_RX_IN_I(mon), .CHARGE_PUMP_EN_O(pump),
      .TX_OUT_OE_N_O(tx_oe_n), .RX_OUT_OE_N_O(rx_oe_n), .MONITOR_RX_OUT_O(mon_o),
      .STATE_O(st), .LINES_VALID_O(lv));

   task automatic fail(input string m);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait for a power state
   task automatic wt(input pwr_state_t s, input int n);
      int i;
      i = 0;
      comparisons++;
      while (st !== s && i < n) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (st !== s) fail("power state not reached in time");
   endtask

   task automatic hold(input pwr_state_t s, input int n);
      comparisons++;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (st !== s) begin
            fail("power state left too early");
            return;
         end
      end
   endtask

   task automatic lvw(input logic e, input int n);
      int i;
      i = 0;
      comparisons++;
      while (lv !== e && i < n) begin
         @(posedge clk);
         #1;
         i++;
      end
      if (lv !== e) fail("line status late");
   endtask

   task automatic outs(input logic p, input logic t, input logic r);
      comparisons++;
      if (pump !== p || tx_oe_n !== t || rx_oe_n !== r) fail("enables wrong for state");
   endtask

   task automatic tog(input int i);
      @(posedge clk);
      lin[i] <= ~lin[i];
   endtask

   task automatic summarize;
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Run takes roughly 8700 cycles; generous margin
   initial begin
      cyc(30000);
      fail("watchdog expired");
      summarize();
   end

   initial begin
      cyc(16);
      rstn <= 1'b1;
      cyc(2);
      #1;
      outs(1'b1, 1'b0, 1'b0);
      hold(PWR_ACTIVE, IDLE + 20);
      @(posedge clk);
      off_n <= 1'b0;
      wt(PWR_MANUAL_DOWN, 8);
      outs(1'b0, 1'b1, 1'b1);
      @(posedge clk);
      mon <= 1'b1;
      cyc(4);
      #1;
      comparisons++;
      if (mon_o !== 1'b1) fail("monitor output not following");
      @(posedge clk);
      lvl <= '0;
      cyc(INVL - 5);
      #1;
      lvw(1'b1, 0);
      lvw(1'b0, 20);
      hold(PWR_MANUAL_DOWN, 2);
      @(posedge clk);
      lvl <= 3'h4;
      lvw(1'b1, `INVH_CYCLES + 6);
      // Shutdown released alone with keep-awake low must not wake
      @(posedge clk);
      awake <= 1'b0;
      cyc(2);
      off_n <= 1'b1;
      hold(PWR_MANUAL_DOWN, 100);
      tog(0);
      wt(PWR_WAKING, 8);
      outs(1'b1, 1'b1, 1'b0);
      wt(PWR_ACTIVE, WK);
      for (int i = 0; i < `NUM_TX + `NUM_RX; i++) begin
         hold(PWR_ACTIVE, IDLE - WK - 20);
         wt(PWR_AUTO_DOWN, IDLE);
         outs(1'b0, 1'b1, 1'b0);
         hold(PWR_AUTO_DOWN, 50);
         tog(i);
         wt(PWR_WAKING, 6);
         wt(PWR_ACTIVE, WK);
      end
      // Late keep-awake pulse must restart the interval
      @(posedge clk);
      awake <= 1'b1;
      cyc(3);
      awake <= 1'b0;
      hold(PWR_ACTIVE, IDLE - 10);
      wt(PWR_AUTO_DOWN, 30);
      @(posedge clk);
      awake <= 1'b1;
      wt(PWR_WAKING, 6);
      wt(PWR_ACTIVE, WK);
      @(posedge clk);
      mode <= 2'h1;
      lvl <= '0;
      wt(PWR_MANUAL_DOWN, INVL + 20);
      @(posedge clk);
      lvl <= '1;
      wt(PWR_ACTIVE, WK + 30);
      @(posedge clk);
      mode <= 2'h2;
      lvl <= '0;
      wt(PWR_MANUAL_DOWN, INVL + 20);
      @(posedge clk);
      lvl <= '1;
      hold(PWR_MANUAL_DOWN, 100);
      tog(1);
      wt(PWR_ACTIVE, WK + 10);
      @(posedge clk);
      mode <= 2'h3;
      off_n <= 1'b0;
      wt(PWR_MANUAL_DOWN, 8);
      @(posedge clk);
      off_n <= 1'b1;
      wt(PWR_ACTIVE, WK + 10);
      wt(PWR_AUTO_DOWN, IDLE + 20);
      @(posedge clk);
      mode <= 2'h0;
      off_n <= 1'b0;
      awake <= 1'b0;
      wt(PWR_MANUAL_DOWN, 8);
      @(posedge clk);
      off_n <= 1'b1;
      awake <= 1'b1;
      wt(PWR_ACTIVE, WK + 10);
      hold(PWR_ACTIVE, IDLE + 20);
      summarize();
   end
endmodule
`default_nettype wire
